//--- logic/asr_pkg.sv
// package for the asynchronous static ram controller
// assumes a 20 mhz system clock; the ram timings other than gate access, address to end and address setup are turned into cycle counts here
package asr_pkg;

   // ==========================================================
   // clock and geometry
   localparam int ASR_CLK_MHZ = 20;
   localparam int ASR_CLK_PS = 1000000 / ASR_CLK_MHZ;
   localparam int ASR_ADDR_W = 18;
   localparam int ASR_DATA_W = 16;
   localparam int ASR_LANE_W = 8;

   // ==========================================================
   // ram timings in ps, slow grade figures (the fast grade is covered by them)
   localparam int ASR_T_CYCLE_PS = 15000;
   localparam int ASR_T_ACCESS_PS = 15000;
   localparam int ASR_T_GATE_ACCESS_PS = 7000;
   localparam int ASR_T_RELEASE_PS = 7000;
   localparam int ASR_T_WR_PULSE_PS = 12000;
   localparam int ASR_T_ADDR_TO_END_PS = 12000;
   localparam int ASR_T_DATA_SETUP_PS = 7000;
   localparam int ASR_T_ADDR_SETUP_PS = 0;
   localparam int ASR_T_HOLD_PS = 0;

   // least times round up, never below one cycle
   function automatic int asr_cyc_min(input int ps);
      int n;
      n = (ps + ASR_CLK_PS - 1) / ASR_CLK_PS;
      return (n < 1) ? 1 : n;
   endfunction

   localparam int ASR_CYC_CYCLE = asr_cyc_min(ASR_T_CYCLE_PS);
   localparam int ASR_CYC_ACCESS = asr_cyc_min(ASR_T_ACCESS_PS);
   localparam int ASR_CYC_RELEASE = asr_cyc_min(ASR_T_RELEASE_PS);
   localparam int ASR_CYC_WR_PULSE = asr_cyc_min(ASR_T_WR_PULSE_PS);
   localparam int ASR_CYC_DATA_SETUP = asr_cyc_min(ASR_T_DATA_SETUP_PS);
   localparam int ASR_CYC_HOLD = asr_cyc_min(ASR_T_HOLD_PS);
   localparam int ASR_CNT_W = 4;

   // ==========================================================
   // reset values of the pins
   localparam logic ASR_STROBE_IDLE = 1'b1;

   typedef enum logic [4:0] {
      ASR_IDLE = 5'h01,
      ASR_READ = 5'h02,
      ASR_WRITE = 5'h04,
      ASR_HOLD = 5'h08,
      ASR_TURN = 5'h10
   } asr_state_t;

endpackage

//--- logic/asr_timer.sv
// down counter that times one phase of a ram cycle
// assumes load and the count come from logic on the same clock
`timescale 1ns/1ns
module asr_timer
   import asr_pkg::*;
#(
   parameter int WIDTH = ASR_CNT_W
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   output logic done
);

   // ==========================================================
   // elaboration check
   if (WIDTH < 2) begin : g_bad_width
      $error("asr_timer width too small");
   end

   logic [WIDTH-1:0] remain;

   // ==========================================================
   // counter
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         remain <= '0;
      end else if (load) begin
         remain <= count;
      end else if (remain != '0) begin
         remain <= remain - 1'b1;
      end
   end

   // done is high in the last cycle of a loaded count; it must not look at load,
   // because the sequencer raises load from done and the two would chase each other
   assign done = (remain == {{(WIDTH-1){1'b0}}, 1'b1});

endmodule

//--- logic/asr_ctrl.sv
// controller that drives a 256k x 16 asynchronous static ram from its pins
// assumes the ram sits on a board bus; data_bus is split into in, out and enable
// How it works
// - write strobe stays high throughout a read
// - read cycle lasts cycle time; data taken after
// - select and address together, data after access time
// - write cycle lasts at least the cycle time
// - write occurs while select and strobe both low
// - address set before, held after the write (the code loads it on the same edge that lowers the strobe)
// - write strobe low pulse meets least width
// - select low long enough before write ends
// - data set before, held after write end
`timescale 1ns/1ns
module asr_ctrl
   import asr_pkg::*;
#(
   parameter int ADDR_W = ASR_ADDR_W,
   parameter int DATA_W = ASR_DATA_W
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic [1:0] req_lanes,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic [ADDR_W-1:0] ram_addr,
   output logic chip_select_n,
   output logic write_strobe_n,
   output logic output_gate_n,
   output logic low_lane_enable_n,
   output logic high_lane_enable_n,
   input wire logic [DATA_W-1:0] data_bus_in,
   output logic [DATA_W-1:0] data_bus_out,
   output logic data_bus_oe
);

   // ==========================================================
   // elaboration check
   if (ADDR_W != ASR_ADDR_W || DATA_W != 2 * ASR_LANE_W) begin : g_bad_geometry
      $error("asr_ctrl geometry does not match the ram");
   end

   // longest wait must fit the timer
   localparam logic [ASR_CNT_W-1:0] CYC_READ = ASR_CNT_W'(
      (ASR_CYC_ACCESS > ASR_CYC_CYCLE ? ASR_CYC_ACCESS : ASR_CYC_CYCLE) + 1);
   localparam int WR_MIN = (ASR_CYC_WR_PULSE > ASR_CYC_DATA_SETUP) ?
      ASR_CYC_WR_PULSE : ASR_CYC_DATA_SETUP;
   localparam logic [ASR_CNT_W-1:0] CYC_WRITE = ASR_CNT_W'(
      WR_MIN > ASR_CYC_CYCLE ? WR_MIN : ASR_CYC_CYCLE);
   localparam logic [ASR_CNT_W-1:0] CYC_HOLD = ASR_CNT_W'(ASR_CYC_HOLD);
   localparam logic [ASR_CNT_W-1:0] CYC_TURN = ASR_CNT_W'(ASR_CYC_RELEASE);
   localparam int CNT_LIMIT = 1 << ASR_CNT_W;

   // a count that wraps in the casts above would cut a phase below the ram's
   // least time, so a slower ram or a faster clock must widen the timer first
   if (ASR_CYC_ACCESS + 1 >= CNT_LIMIT || ASR_CYC_CYCLE + 1 >= CNT_LIMIT
         || WR_MIN >= CNT_LIMIT || ASR_CYC_HOLD >= CNT_LIMIT
         || ASR_CYC_RELEASE >= CNT_LIMIT) begin : g_bad_count
      $error("asr_ctrl phase count does not fit the timer");
   end

   asr_state_t state;
   asr_state_t next_state;
   logic timer_load;
   logic timer_done;
   logic [ASR_CNT_W-1:0] timer_count;
   logic take;
   logic [DATA_W-1:0] bus_sync1;
   logic [DATA_W-1:0] bus_sync2;
   logic read_end;

   // ==========================================================
   // phase timer
   asr_timer #(
      .WIDTH(ASR_CNT_W)
   ) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(timer_load),
      .count(timer_count),
      .done(timer_done)
   );

   assign req_ready = (state == ASR_IDLE);
   assign take = req_valid && req_ready;

   // ==========================================================
   // sequencer
   always_comb begin
      next_state = state;
      timer_load = 1'b0;
      timer_count = '0;
      case (state)
         ASR_IDLE: begin
            if (take) begin
               timer_load = 1'b1;
               timer_count = req_write ? CYC_WRITE : CYC_READ;
               next_state = req_write ? ASR_WRITE : ASR_READ;
            end
         end
         ASR_READ: begin
            if (timer_done) begin
               // bus must be released before the next cycle may drive it
               timer_load = 1'b1;
               timer_count = CYC_TURN;
               next_state = ASR_TURN;
            end
         end
         ASR_WRITE: begin
            if (timer_done) begin
               timer_load = 1'b1;
               timer_count = CYC_HOLD;
               next_state = ASR_HOLD;
            end
         end
         ASR_HOLD: begin
            if (timer_done) begin
               next_state = ASR_IDLE;
            end
         end
         ASR_TURN: begin
            if (timer_done) begin
               next_state = ASR_IDLE;
            end
         end
         default: begin
            next_state = ASR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= ASR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // address, lanes and write data stay fixed through the cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ram_addr <= '0;
         data_bus_out <= '0;
         low_lane_enable_n <= ASR_STROBE_IDLE;
         high_lane_enable_n <= ASR_STROBE_IDLE;
      end else if (take) begin
         ram_addr <= req_addr;
         data_bus_out <= req_wdata;
         low_lane_enable_n <= !req_lanes[0];
         high_lane_enable_n <= !req_lanes[1];
      end
   end

   // ==========================================================
   // strobes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chip_select_n <= ASR_STROBE_IDLE;
         write_strobe_n <= ASR_STROBE_IDLE;
         output_gate_n <= ASR_STROBE_IDLE;
         data_bus_oe <= 1'b0;
      end else begin
         // select and strobe fall together on the same edge that loads the address
         chip_select_n <= !(next_state == ASR_READ || next_state == ASR_WRITE);
         write_strobe_n <= !(next_state == ASR_WRITE);
         // gate stays high in writes so the ram never fights us
         output_gate_n <= !(next_state == ASR_READ);
         // drive data through write and its hold; released in reads
         data_bus_oe <= (next_state == ASR_WRITE || next_state == ASR_HOLD);
      end
   end

   // ==========================================================
   // read data capture, pins synchronised first
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_sync1 <= '0;
         bus_sync2 <= '0;
      end else begin
         bus_sync1 <= data_bus_in;
         bus_sync2 <= bus_sync1;
      end
   end

   // the word in the second stage was taken one cycle into the select window,
   // well after the access time, and arrives here as the bus is turned round
   assign read_end = (state == ASR_TURN) && timer_done;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= read_end;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rsp_rdata <= '0;
      end else if (read_end) begin
         rsp_rdata <= bus_sync2;
      end
   end

endmodule

//--- sim/asr_ctrl_sva.sv
// pin checker for the sram controller
// assumes a bind onto asr_ctrl
`timescale 1ns/1ns
module asr_ctrl_sva (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic [1:0] req_lanes,
   input wire logic rsp_valid,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic output_gate_n,
   input wire logic low_lane_enable_n,
   input wire logic high_lane_enable_n,
   input wire logic data_bus_oe
);
   // ====
   // cycle shapes
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire rd = req_valid && req_ready && !req_write;
   wire wr = req_valid && req_ready && req_write;
   property p_rd_hi; rd |=> write_strobe_n [*3]; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("strobe low in read");
   property p_rd_sel;
      rd |=> (!chip_select_n && !output_gate_n) [*2] ##1 (chip_select_n && output_gate_n);
   endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("read select");
   property p_rd_rsp; rd |=> !rsp_valid [*3] ##1 rsp_valid; endproperty
   a_rd_rsp: assert property (p_rd_rsp) else $error("read answer");
   property p_rsp_src; rsp_valid |-> $past(output_gate_n) && !$past(output_gate_n, 2); endproperty
   a_rsp_src: assert property (p_rsp_src) else $error("answer without read");
   property p_wr;
      wr |=> (!chip_select_n && !write_strobe_n && data_bus_oe)
         ##1 (chip_select_n && write_strobe_n && data_bus_oe) ##1 !data_bus_oe;
   endproperty
   a_wr: assert property (p_wr) else $error("write");
   property p_wr_cyc; wr |=> !req_ready [*2] ##1 req_ready; endproperty
   a_wr_cyc: assert property (p_wr_cyc) else $error("write cycle");
   property p_gate; (data_bus_oe || !write_strobe_n) |-> output_gate_n; endproperty
   a_gate: assert property (p_gate) else $error("gate low in write");
   property p_lanes;
      (rd || wr) |=> {high_lane_enable_n, low_lane_enable_n} == ~$past(req_lanes);
   endproperty
   a_lanes: assert property (p_lanes) else $error("lane pins");
endmodule

bind asr_ctrl asr_ctrl_sva i_sva (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
   .req_ready(req_ready), .req_write(req_write), .req_lanes(req_lanes),
   .rsp_valid(rsp_valid), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
   .output_gate_n(output_gate_n), .low_lane_enable_n(low_lane_enable_n),
   .high_lane_enable_n(high_lane_enable_n), .data_bus_oe(data_bus_oe));

//--- sim/asr_ram_model.sv
// behavioural 256k x 16 static ram on the controller pins
// assumes the data pins are split into out, enable and in
`timescale 1ns/1ns
module asr_ram_model
   import asr_pkg::*;
#(
   parameter int DLY = 7
) (
   input wire logic [ASR_ADDR_W-1:0] ram_addr,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic output_gate_n,
   input wire logic low_lane_enable_n,
   input wire logic high_lane_enable_n,
   input wire logic data_bus_oe,
   input wire logic [ASR_DATA_W-1:0] data_bus_out,
   output logic [ASR_DATA_W-1:0] data_bus_in
);
   logic [ASR_DATA_W-1:0] mem [0:(1 << ASR_ADDR_W) - 1];
   logic [ASR_DATA_W-1:0] junk = 16'h3c3c;
   logic [ASR_DATA_W-1:0] bus;
   logic rd;
   // undriven lanes flip so stale data never looks valid
   always #25 junk = ~junk;
   assign rd = !chip_select_n && !output_gate_n
      && write_strobe_n;
   always @* begin
      bus = data_bus_oe ? data_bus_out : junk;
      if (rd && !low_lane_enable_n) bus[7:0] = mem[ram_addr][7:0];
      if (rd && !high_lane_enable_n) bus[15:8] = mem[ram_addr][15:8];
   end
   always @* begin
      if (!chip_select_n && !write_strobe_n && !low_lane_enable_n) mem[ram_addr][7:0] = bus[7:0];
      if (!chip_select_n && !write_strobe_n && !high_lane_enable_n) mem[ram_addr][15:8] = bus[15:8];
   end
   // one delay gives access, hold and turn-off times
   assign #(DLY) data_bus_in = bus;
endmodule

//--- sim/tb_top.sv
// self-checking bench for the sram controller
// assumes the package, controller, ram model and checker are compiled first
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top
   import asr_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [ASR_ADDR_W-1:0] req_addr = '0;
   logic [ASR_DATA_W-1:0] req_wdata = '0;
   logic [1:0] req_lanes = 2'h0;
   logic req_ready, rsp_valid, chip_select_n, write_strobe_n, output_gate_n;
   logic low_lane_enable_n, high_lane_enable_n, data_bus_oe;
   logic [ASR_DATA_W-1:0] rsp_rdata, data_bus_in, data_bus_out, q;
   logic [ASR_ADDR_W-1:0] ram_addr;
   int fail_count = 0;
   int tests_run = 0;
   always #25 clk_sys = ~clk_sys;
   asr_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ram_addr(ram_addr),
      .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
      .output_gate_n(output_gate_n), .low_lane_enable_n(low_lane_enable_n),
      .high_lane_enable_n(high_lane_enable_n), .data_bus_in(data_bus_in),
      .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
   asr_ram_model i_ram (.ram_addr(ram_addr), .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n),
      .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n),
      .data_bus_oe(data_bus_oe), .data_bus_out(data_bus_out), .data_bus_in(data_bus_in));
   // ====
   // shared tasks
   task automatic complete_run();
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic tick(inout int n);
      @(negedge clk_sys);
      n++;
      if (n > 20) begin
         fail_count++;
         complete_run();
      end
   endtask
   task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d,
         input logic [1:0] l, output logic [15:0] r);
      int n;
      n = 0;
      while (req_ready !== 1'b1) tick(n);
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_lanes = l;
      @(negedge clk_sys);
      req_valid = 1'b0;
      while (!w && rsp_valid !== 1'b1) tick(n);
      r = rsp_rdata;
   endtask
   // ====
   // scenarios
   task automatic t_idle();
      logic [4:0] pins;
      pins = {chip_select_n, write_strobe_n, output_gate_n, data_bus_oe, req_ready};
      `CHK(pins, 5'h1d)
   endtask
   task automatic t_words();
      logic [17:0] a [3] = '{18'h3ffff, 18'h00001, 18'h20000};
      for (int i = 0; i < 3; i++) op(1'b1, a[i], 16'ha55a ^ i[15:0], 2'h3, q);
      for (int i = 0; i < 3; i++) begin
         op(1'b0, a[i], 16'h0000, 2'h3, q);
         `CHK(q, 16'ha55a ^ i[15:0])
      end
   endtask
   task automatic t_lanes();
      op(1'b1, 18'h00002, 16'h1234, 2'h3, q);
      op(1'b1, 18'h00002, 16'hffff, 2'h1, q);
      op(1'b1, 18'h00002, 16'habcd, 2'h2, q);
      op(1'b1, 18'h00002, 16'h0000, 2'h0, q);
      op(1'b0, 18'h00002, 16'h0000, 2'h3, q);
      `CHK(q, 16'habff)
      op(1'b0, 18'h00002, 16'h0000, 2'h2, q);
      `CHK(q[15:8], 8'hab)
   endtask
   task automatic t_abort();
      int n;
      n = 0;
      op(1'b1, 18'h00003, 16'h5555, 2'h3, q);
      while (req_ready !== 1'b1) tick(n);
      // start a read and cut it with reset one cycle in
      req_valid = 1'b1;
      req_write = 1'b0;
      req_addr = 18'h00003;
      @(negedge clk_sys);
      req_valid = 1'b0;
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      `CHK({chip_select_n, output_gate_n, rsp_valid}, 3'h6)
      rst = 1'b0;
      @(negedge clk_sys);
      t_idle();
      op(1'b0, 18'h00003, 16'h0000, 2'h3, q);
      `CHK(q, 16'h5555)
      op(1'b0, 18'h00001, 16'h0000, 2'h3, q);
      `CHK(q, 16'ha55b)
   endtask
   initial begin
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      t_idle();
      t_words();
      t_lanes();
      t_abort();
      complete_run();
   end
endmodule
